/* bench/mac_unit_control_chk.sv */
// Port-level assertions for the MAC unit control block.
`timescale 1ns/1ps
module mac_unit_control_chk (
	input  wire logic             clk_i,    // Core clock.
	input  wire logic             nrst_i,   // Async reset, active low.
	input  wire mac_pkg::wb_req_t wb_req_i, // Bus request group.
	input  wire logic [31:0]      wb_dat_o, // Read data.
	input  wire logic             wb_ack_o, // Bus acknowledge.
	input  wire logic             busy_o    // Operation in progress.
);
	import mac_pkg::*;
	logic req;
	logic rd;
	logic op_wr;
	logic clr_wr;
	assign req = wb_req_i.cyc && wb_req_i.stb;
	assign rd = wb_ack_o && !wb_req_i.we;
	assign op_wr = wb_ack_o && wb_req_i.we
		&& (wb_req_i.adr == 8'h04 || wb_req_i.adr == 8'h08);
	assign clr_wr = wb_ack_o && wb_req_i.we && wb_req_i.adr == 8'h00
		&& wb_req_i.sel[0] && wb_req_i.dat[5];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// =========================================
	// Bus and operation properties.
	// A run lasts four busy cycles unless a clear aborts it or a new
	// operand write restarts the count.
	sequence run_s;
		busy_o [*4] ##1 !busy_o;
	endsequence
	sequence abort_s;
		##[0:4] clr_wr;
	endsequence
	sequence again_s;
		##[1:4] op_wr;
	endsequence
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_resp_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(req))
		else $error("ack without a request");
	busy_start_a: assert property ($rose(busy_o) |-> $past(op_wr))
		else $error("operation started without operand write");
	busy_run_a: assert property ($rose(busy_o)
		|-> run_s or abort_s or again_s)
		else $error("operation length wrong");
	clear_abort_a: assert property (clr_wr |=> !busy_o)
		else $error("clear did not abort operation");
	clear_self_a: assert property (rd && wb_req_i.adr == 8'h00
		|-> wb_dat_o[5] == 1'b0 && wb_dat_o[15:9] == 7'h00)
		else $error("clear bit or reserved bits read as one");
	upper_zero_a: assert property (rd |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	status_busy_a: assert property (rd && wb_req_i.adr == 8'h18
		|-> wb_dat_o[0] == $past(busy_o))
		else $error("status does not show busy");
	unmapped_a: assert property (rd && wb_req_i.adr == 8'h1C
		|-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule

/* bench/mac_unit_control_test.sv */
// Self-checking bench for the MAC unit control block.
`timescale 1ns/1ps
module mac_unit_control_test;
	import mac_pkg::*;
	logic        clk_i;
	logic        nrst_i;
	wb_req_t     req;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        busy_o;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc_n = 0;
	mac_unit_control dut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_req_i(req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hung handshake would stall forever, so the run is capped.
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 3000)
		begin
			n_fail++;
			end_sim;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req <= '{1'b1, 1'b1, we, a, 4'h3, d};
		// Only the cycle cap ends a wait for an answer that never comes.
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, {16'h0000, d}, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task automatic idle;
		do
		begin
			@(posedge clk_i);
		end
		while (busy_o !== 1'b0);
	endtask
	task automatic op(input logic [7:0] c, input logic [7:0] a,
		input logic [15:0] d, input logic [15:0] e);
		wr(8'h00, {8'h00, c});
		wr(a, d);
		idle;
		rd(8'h0C, {16'h0000, e});
	endtask
	initial
	begin
		req = '0;
		nrst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 8; i++)
			rd(8'(4 * i), 32'h0000_0000);
		$display("test reset done");
		wr(8'h04, 16'h0003);
		rd(8'h18, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		wr(8'h08, 16'hFFFE);
		idle;
		rd(8'h0C, 32'h0000_FFFA);
		rd(8'h14, 32'h0000_00FF);
		op(8'h0A, 8'h04, 16'h0002, 16'hFFF6);
		op(8'h0C, 8'h08, 16'h0007, 16'hFFF2);
		op(8'h0E, 8'h04, 16'h0001, 16'hFFEB);
		$display("test modes done");
		op(8'h11, 8'h04, 16'h0100, 16'h0000);
		rd(8'h08, 32'h0000_0100);
		op(8'h09, 8'h04, 16'hFFFF, 16'hFF00);
		rd(8'h10, 32'h0000_00FF);
		op(8'h49, 8'h04, 16'h0003, 16'hFF00);
		rd(8'h10, 32'h0000_00FF);
		$display("test square done");
		op(8'h0D, 8'h04, 16'h0001, 16'hFF00);
		rd(8'h00, 32'h0000_008D);
		wr(8'h04, 16'h0001);
		rd(8'h00, 32'h0000_000D);
		idle;
		rd(8'h00, 32'h0000_008D);
		wr(8'h00, 16'h002D);
		rd(8'h00, 32'h0000_000D);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		$display("test overflow done");
		wr(8'h00, 16'h0011);
		wr(8'h04, 16'h0005);
		wr(8'h00, 16'h0031);
		rd(8'h18, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h00, 32'h0000_0011);
		$display("test abort done");
		wr(8'h00, 16'h0108);
		wr(8'h08, 16'h0004);
		idle;
		wr(8'h04, 16'h0003);
		wr(8'h00, 16'h0108);
		idle;
		rd(8'h0C, 32'h0000_000C);
		rd(8'h04, 32'h0000_0003);
		rd(8'h00, 32'h0000_0108);
		$display("test divide bit done");
		end_sim;
	end
endmodule
bind mac_unit_control mac_unit_control_chk chk (.clk_i(clk_i),
	.nrst_i(nrst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .busy_o(busy_o));

/* design/mac_map.svh */
// Register map, field positions, reset values and timing of the MAC unit.
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ============================================================
// Register indices; byte address is four times the index.
`define MAC_IDX_CTRL     6'h00
`define MAC_IDX_OPA      6'h01
`define MAC_IDX_OPB      6'h02
`define MAC_IDX_ACC0     6'h03
`define MAC_IDX_ACC1     6'h04
`define MAC_IDX_ACC2     6'h05
`define MAC_IDX_STATUS   6'h06

// ============================================================
// Control register fields.
`define MAC_BIT_SIGNED   0
`define MAC_BIT_ACCUM    1
`define MAC_BIT_SUB      2
`define MAC_BIT_OPCOUNT  3
`define MAC_BIT_SQUARE   4
`define MAC_BIT_CLEAR    5
`define MAC_BIT_INHIBIT  6
`define MAC_BIT_OVF      7
`define MAC_BIT_DIV      8
`define MAC_CTRL_WMASK   16'h015F
`define MAC_CTRL_RESET   16'h0000
`define MAC_DATA_RESET   16'h0000
`define MAC_ACC_RESET    40'h00_0000_0000

// ============================================================
// Timing: start value of the run counter, counted down to zero; a run is four busy cycles.
`define MAC_RUN_LAST     3'h3

`endif

/* design/mac_pkg.sv */
// Types shared by the MAC unit and its bus.
package mac_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef enum logic {
		OP_IDLE,
		OP_RUN
	} op_state_t;

endpackage

/* design/mac_unit_control.sv */
// Multiply-accumulate unit control with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "mac_map.svh"

module mac_unit_control (
	input  wire logic             clk_i,    // Core clock, 10 MHz.
	input  wire logic             nrst_i,   // Async reset, active low.
	input  wire mac_pkg::wb_req_t wb_req_i, // Bus request group.
	output logic [31:0]           wb_dat_o, // Read data, registered.
	output logic                  wb_ack_o, // Bus acknowledge.
	output logic                  busy_o    // Operation in progress.
);
	import mac_pkg::*;

	// ============================================================
	// Storage.
	logic [15:0] ctrl;
	logic        overflow_flag;
	logic [15:0] operand_a;
	logic [15:0] operand_b;
	logic [39:0] accumulator;
	logic        a_written;
	logic        b_written;
	op_state_t   state;
	logic [2:0]  run_cnt;

	// ============================================================
	// Bus decode.
	logic        req_hit;
	logic        wr_go;
	logic [5:0]  idx;
	logic        wr_ctrl;
	logic        wr_a;
	logic        wr_b;
	logic        wr_acc0;
	logic        wr_acc1;
	logic        wr_acc2;
	logic        clear_cmd;
	logic [15:0] wdata;
	logic [15:0] wmask;

	assign req_hit = wb_req_i.cyc & wb_req_i.stb;
	// Writes land on the edge at which the master sees ack high.
	assign wr_go   = req_hit & wb_req_i.we & wb_ack_o;
	assign idx     = wb_req_i.adr[7:2];
	assign wr_ctrl = wr_go && (idx == `MAC_IDX_CTRL);
	assign wr_a    = wr_go && (idx == `MAC_IDX_OPA);
	assign wr_b    = wr_go && (idx == `MAC_IDX_OPB);
	assign wr_acc0 = wr_go && (idx == `MAC_IDX_ACC0);
	assign wr_acc1 = wr_go && (idx == `MAC_IDX_ACC1);
	assign wr_acc2 = wr_go && (idx == `MAC_IDX_ACC2);
	assign wdata   = wb_req_i.dat[15:0];
	assign wmask   = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

	// Clear is a command, never stored, so it always reads back as zero.
	// Self-clearing command
	assign clear_cmd = wr_ctrl & wb_req_i.sel[0]
		& wb_req_i.dat[`MAC_BIT_CLEAR];

	function automatic logic [15:0] merge16(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [15:0] mask
	);
		merge16 = (old_v & ~mask) | (new_v & mask);
	endfunction

	// ============================================================
	// Start decision.
	logic square_on;
	logic single_on;
	logic start;
	logic [15:0] next_opa;
	logic [15:0] next_opb;

	assign square_on = ctrl[`MAC_BIT_SQUARE];
	assign single_on = ctrl[`MAC_BIT_OPCOUNT];
	assign next_opa  = merge16(operand_a, wdata, wmask);
	assign next_opb  = merge16(operand_b, wdata, wmask);

	// The divide bit is held but no divide path exists, so neither
	// count select nor square can reach one.
	// No divide path
	always_comb
	begin
		start = 1'b0;
		if (clear_cmd)
			start = 1'b0;
		else if (square_on)
			start = wr_a | wr_b;
		else if (single_on)
			start = wr_a | wr_b;
		else
			start = (wr_a & b_written) | (wr_b & a_written);
	end

	// ============================================================
	// Control register.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ctrl <= `MAC_CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= merge16(ctrl, wdata, wmask & `MAC_CTRL_WMASK);
	end

	// ============================================================
	// Operand registers.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			operand_a <= `MAC_DATA_RESET;
			operand_b <= `MAC_DATA_RESET;
		end
		else if (clear_cmd)
		begin
			operand_a <= `MAC_DATA_RESET;
			operand_b <= `MAC_DATA_RESET;
		end
		else if (wr_a)
		begin
			operand_a <= next_opa;
			if (square_on)
				operand_b <= next_opa;
		end
		else if (wr_b)
		begin
			operand_b <= next_opb;
			if (square_on)
				operand_a <= next_opb;
		end
	end

	// ============================================================
	// Operand written flags.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			a_written <= 1'b0;
			b_written <= 1'b0;
		end
		else if (clear_cmd || start)
		begin
			a_written <= 1'b0;
			b_written <= 1'b0;
		end
		else if (!square_on && !single_on)
		begin
			if (wr_a)
				a_written <= 1'b1;
			if (wr_b)
				b_written <= 1'b1;
		end
	end

	// ============================================================
	// Operation sequencer.
	logic finish;

	// A start in the finishing cycle commits the old result first,
	// since the operands change only at that same edge.
	assign finish = (state == OP_RUN) && (run_cnt == 3'h0) && !clear_cmd;
	assign busy_o = (state == OP_RUN);

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state   <= OP_IDLE;
			run_cnt <= 3'h0;
		end
		else if (clear_cmd)
		begin
			state   <= OP_IDLE;
			run_cnt <= 3'h0;
		end
		else if (start)
		begin
			state   <= OP_RUN;
			run_cnt <= `MAC_RUN_LAST;
		end
		else
		begin
			case (state)
			OP_IDLE:
				run_cnt <= 3'h0;
			OP_RUN:
			begin
				if (run_cnt == 3'h0)
					state <= OP_IDLE;
				else
					run_cnt <= run_cnt - 3'h1;
			end
			default:
				state <= OP_IDLE;
			endcase
		end
	end

	// ============================================================
	// Arithmetic.
	logic               is_unsigned;
	logic signed [16:0] ext_a;
	logic signed [16:0] ext_b;
	logic signed [33:0] product;
	logic signed [41:0] prod_w;
	logic signed [41:0] acc_w;
	logic signed [41:0] result;
	logic               result_ovf;

	assign is_unsigned = ctrl[`MAC_BIT_SIGNED];
	assign ext_a   = {~is_unsigned & operand_a[15], operand_a};
	assign ext_b   = {~is_unsigned & operand_b[15], operand_b};
	assign product = ext_a * ext_b;
	assign prod_w  = {{8{product[33]}}, product};
	assign acc_w   = is_unsigned ? {2'b00, accumulator}
		: {{2{accumulator[39]}}, accumulator};

	// Widening to 42 bits lets one compare catch overflow both ways.
	// Operation select
	always_comb
	begin
		case ({ctrl[`MAC_BIT_SUB], ctrl[`MAC_BIT_ACCUM]})
		2'b00:
			result = prod_w;
		2'b01:
			result = acc_w + prod_w;
		2'b10:
			result = -prod_w;
		2'b11:
			result = acc_w - prod_w;
		default:
			result = prod_w;
		endcase
	end

	always_comb
	begin
		if (is_unsigned)
			result_ovf = (result[41:40] != 2'b00);
		else
			result_ovf = (result[41:39] != 3'h0)
				&& (result[41:39] != 3'h7);
	end

	// ============================================================
	// Accumulator.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			accumulator <= `MAC_ACC_RESET;
		else if (clear_cmd)
			accumulator <= `MAC_ACC_RESET;
		else if (finish && !ctrl[`MAC_BIT_INHIBIT])
			accumulator <= result[39:0];
		else if (wr_acc0)
			accumulator[15:0] <= merge16(accumulator[15:0],
				wdata, wmask);
		else if (wr_acc1)
			accumulator[31:16] <= merge16(accumulator[31:16],
				wdata, wmask);
		else if (wr_acc2 && wb_req_i.sel[0])
			accumulator[39:32] <= wdata[7:0];
	end

	// ============================================================
	// Overflow flag.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			overflow_flag <= 1'b0;
		else if (clear_cmd || start)
			overflow_flag <= 1'b0;
		else if (finish)
			overflow_flag <= result_ovf;
	end

	// ============================================================
	// Bus answer: one wait state, unmapped reads return zero.
	logic [15:0] ctrl_view;
	logic [31:0] next_rdata;

	always_comb
	begin
		ctrl_view = ctrl & `MAC_CTRL_WMASK;
		ctrl_view[`MAC_BIT_OVF] = overflow_flag;
	end

	always_comb
	begin
		case (idx)
		`MAC_IDX_CTRL:
			next_rdata = {16'h0000, ctrl_view};
		`MAC_IDX_OPA:
			next_rdata = {16'h0000, operand_a};
		`MAC_IDX_OPB:
			next_rdata = {16'h0000, operand_b};
		`MAC_IDX_ACC0:
			next_rdata = {16'h0000, accumulator[15:0]};
		`MAC_IDX_ACC1:
			next_rdata = {16'h0000, accumulator[31:16]};
		`MAC_IDX_ACC2:
			next_rdata = {24'h00_0000, accumulator[39:32]};
		`MAC_IDX_STATUS:
			next_rdata = {31'h0000_0000, busy_o};
		default:
			next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req_hit & ~wb_ack_o;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (req_hit && !wb_ack_o && !wb_req_i.we)
			wb_dat_o <= next_rdata;
	end

endmodule
